// ===== design/supervisor_cfg.svh
// constants of the supervisor block
// Summary of operation
// - an alarm match against the time of day sets alarm_flag at flags bit 6
// - four alarm fields, each with a select bit; a select of 0 compares
// - the select bit is the top bit of each alarm register
// - all selects 1 means no compare, the alarm fires every second
// - seconds only fires once a minute; seconds and minutes once an hour
// - adding hours fires daily; all four fire on an exact date match
// - any other select mix is still compared field by field
// - reading the flags register clears alarm_flag and every other flag
// - watchdog down counter steps on a 32 Hz tick, 31.25 ms period
// - watchdog counts only while osc_enable_n is 0
// - load the timeout at power-up; strobe bit 7 reloads the counter
// - reaching 0 sets watchdog_flag and, if enabled, the interrupt
// - watchdog_flag at flags bit 7, set on timeout, cleared by flags read
// - lock bit 6 of 0 lets timeout bits 5..0 be written; 1 ignores them
// - a timeout value of 0 disables the watchdog
// - supply below interrupt_threshold sets power_fail_flag bit 5 and, if enabled, irq
// - below lockout_threshold all bus access is blocked and ignored
// - supply below backup_supply moves the timekeeper to backup power
// - at power-up reassert switchover and power-fail, then return to main
// - power_fail_flag stays set until the flags register is read
// - only a complete read with write enable high clears the flags
// - interrupt needs source and enable; any one qualified source drives it
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
`define ADDR_FLAGS 15'h7ff0
`define ADDR_ALM_SEC 15'h7ff2
`define ADDR_ALM_MIN 15'h7ff3
`define ADDR_ALM_HOUR 15'h7ff4
`define ADDR_ALM_DATE 15'h7ff5
`define ADDR_IRQ 15'h7ff6
`define ADDR_WDOG 15'h7ff7
`define BIT_WDF 7
`define BIT_AF 6
`define BIT_PF 5
`define BIT_STROBE 7
`define BIT_WLOCK 6
`define BIT_MATCH 7
`define BIT_WIE 7
`define BIT_AIE 6
`define BIT_PFE 5
`define IRQ_RESET 8'h24
`define WDOG_RESET 8'h00
`define CLK_HZ 20000000
`define TICK_HZ 32
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`endif

// ===== design/supervisor_pkg.sv
// types of the supervisor block
package supervisor_pkg;
  typedef enum logic [1:0] {pw_off, pw_reassert, pw_main} pw_state_t;
  typedef logic [7:0] byte_t;
endpackage

// ===== design/alarm_compare.sv
// alarm comparator, evaluated once per seconds update
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module alarm_compare import supervisor_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sec_update,
  input wire byte_t tod_sec,
  input wire byte_t tod_min,
  input wire byte_t tod_hour,
  input wire byte_t tod_date,
  input wire byte_t alm_sec,
  input wire byte_t alm_min,
  input wire byte_t alm_hour,
  input wire byte_t alm_date,
  output logic alarm_hit
);
  typedef struct packed {logic hit;} st_t;
  st_t st_r, st_nxt;
  function automatic logic field_ok(input byte_t alm, input byte_t tod);
    // select 1 skips the field, 0 compares the low seven bits
    field_ok = alm[`BIT_MATCH] || (alm[6:0] == tod[6:0]);
  endfunction
  always_comb begin
    st_nxt = st_r;
    // every combination is compared literally, all-ones fires each second
    st_nxt.hit = sec_update && field_ok(alm_sec, tod_sec) && field_ok(alm_min, tod_min)
      && field_ok(alm_hour, tod_hour) && field_ok(alm_date, tod_date);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign alarm_hit = st_r.hit;
endmodule // alarm_compare

// ===== design/watchdog_counter.sv
// watchdog down counter on a 32 Hz tick
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module watchdog_counter import supervisor_pkg::*; #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int TW = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic osc_enable_n,
  input wire logic reload,
  input wire logic [TW-1:0] timeout,
  output logic expired
);
  typedef struct packed {
    logic [24:0] div;
    logic [TW-1:0] cnt;
    logic loaded;
    logic exp;
  } st_t;
  st_t st_r, st_nxt;
  logic tick;
  assign tick = (st_r.div == 25'(TICK_CYCLES - 1));
  always_comb begin
    st_nxt = st_r;
    st_nxt.exp = 1'b0;
    // prescaler stands still while the oscillator is off
    if (!osc_enable_n) begin
      st_nxt.div = tick ? '0 : st_r.div + 25'd1;
    end
    if (!run || timeout == '0) begin
      st_nxt.loaded = 1'b0;
      st_nxt.cnt = timeout;
    end else if (!st_r.loaded || reload) begin
      st_nxt.loaded = 1'b1;
      st_nxt.cnt = timeout;
    end else if (tick && !osc_enable_n && st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - TW'(1);
      // one pulse on the step into zero, then it rests until reload
      st_nxt.exp = (st_r.cnt == TW'(1));
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign expired = st_r.exp;
endmodule // watchdog_counter

// ===== design/rtc_supervisor_alarm_watchdog.sv
// supervisor: alarm, watchdog, power monitor and its registers
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module rtc_supervisor_alarm_watchdog import supervisor_pkg::*; #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic [14:0] addr,
  input wire byte_t wdata,
  output byte_t rdata,
  output logic rdata_oe_b,
  input wire logic sec_update,
  input wire byte_t tod_sec,
  input wire byte_t tod_min,
  input wire byte_t tod_hour,
  input wire byte_t tod_date,
  input wire logic osc_enable_n,
  input wire logic bandgap_ok,
  input wire logic below_interrupt_threshold,
  input wire logic below_lockout_threshold,
  input wire logic below_backup_supply,
  output logic on_backup_supply,
  output logic irq_active
);
  typedef struct packed {
    pw_state_t pw;
    logic bk;
    logic in_cyc;
    logic cyc_rd;
    logic cyc_wr;
    logic [14:0] cyc_a;
    byte_t wd;
    byte_t alm_sec;
    byte_t alm_min;
    byte_t alm_hour;
    byte_t alm_date;
    byte_t irq_cfg;
    byte_t wdog;
    logic watchdog_flag;
    logic af;
    logic pf;
    byte_t rd;
    logic irq;
  } st_t;
  st_t st_r, st_nxt;
  logic alarm_hit;
  logic wd_expired;
  logic strobe;
  logic lockout;
  logic clr;

  alarm_compare u_alarm (
    .clk(clk),
    .rst_b(rst_b),
    .sec_update(sec_update),
    .tod_sec(tod_sec),
    .tod_min(tod_min),
    .tod_hour(tod_hour),
    .tod_date(tod_date),
    .alm_sec(st_r.alm_sec),
    .alm_min(st_r.alm_min),
    .alm_hour(st_r.alm_hour),
    .alm_date(st_r.alm_date),
    .alarm_hit(alarm_hit)
  );

  watchdog_counter #(.TICK_CYCLES(TICK_CYCLES), .TW(6)) u_wdog (
    .clk(clk),
    .rst_b(rst_b),
    .run(st_r.pw == pw_main),
    .osc_enable_n(osc_enable_n),
    .reload(strobe),
    .timeout(st_r.wdog[5:0]),
    .expired(wd_expired)
  );

  // a cycle ends when chip enable rises; only then does it take effect
  assign lockout = below_lockout_threshold || st_r.pw != pw_main;
  assign strobe = st_r.in_cyc && ce_b && st_r.cyc_wr && st_r.cyc_a == `ADDR_WDOG
    && st_r.wd[`BIT_STROBE] && !lockout;
  // a read whose write enable dropped anywhere in the cycle is not complete
  assign clr = st_r.in_cyc && ce_b && st_r.cyc_rd && !st_r.cyc_wr
    && st_r.cyc_a == `ADDR_FLAGS && !lockout;

  always_comb begin
    st_nxt = st_r;
    // power sequence: reassert backup and power fail before main operation
    case (st_r.pw)
      pw_off: begin
        if (bandgap_ok) begin
          st_nxt.pw = pw_reassert;
        end
      end
      pw_reassert: begin
        st_nxt.bk = 1'b1;
        st_nxt.pf = 1'b1;
        if (!below_backup_supply && !below_lockout_threshold) begin
          st_nxt.pw = pw_main;
        end
      end
      pw_main: begin
        if (!bandgap_ok) begin
          st_nxt.pw = pw_off;
        end
      end
      default: begin
        st_nxt.pw = pw_off;
      end
    endcase
    if (st_r.pw != pw_reassert) begin
      st_nxt.bk = below_backup_supply;
    end
    // bus cycle capture; lockout drops any cycle in progress
    if (lockout) begin
      st_nxt.in_cyc = 1'b0;
    end else if (!ce_b && !st_r.in_cyc) begin
      st_nxt.in_cyc = 1'b1;
      st_nxt.cyc_a = addr;
      st_nxt.cyc_rd = !oe_b;
      st_nxt.cyc_wr = !we_b;
      st_nxt.wd = wdata;
    end else if (!ce_b) begin
      st_nxt.cyc_rd = st_r.cyc_rd || !oe_b;
      st_nxt.cyc_wr = st_r.cyc_wr || !we_b;
      if (!we_b) begin
        st_nxt.wd = wdata;
      end
    end else begin
      st_nxt.in_cyc = 1'b0;
    end
    if (st_r.in_cyc && ce_b && st_r.cyc_wr && !lockout) begin
      case (st_r.cyc_a)
        `ADDR_ALM_SEC: st_nxt.alm_sec = st_r.wd;
        `ADDR_ALM_MIN: st_nxt.alm_min = st_r.wd;
        `ADDR_ALM_HOUR: st_nxt.alm_hour = st_r.wd;
        `ADDR_ALM_DATE: st_nxt.alm_date = st_r.wd;
        `ADDR_IRQ: st_nxt.irq_cfg = st_r.wd;
        `ADDR_WDOG: begin
          // the lock bit as held before this write decides on the timeout
          st_nxt.wdog[`BIT_WLOCK] = st_r.wd[`BIT_WLOCK];
          if (!st_r.wdog[`BIT_WLOCK]) begin
            st_nxt.wdog[5:0] = st_r.wd[5:0];
          end
        end
        default: begin
        end
      endcase
    end
    // flags: a read clears, but a new event in the same cycle wins
    if (clr) begin
      st_nxt.af = 1'b0;
      st_nxt.watchdog_flag = 1'b0;
      if (st_r.pw != pw_reassert) begin
        st_nxt.pf = 1'b0;
      end
    end
    if (alarm_hit) begin
      st_nxt.af = 1'b1;
    end
    if (wd_expired) begin
      st_nxt.watchdog_flag = 1'b1;
    end
    if (below_interrupt_threshold && st_r.pw == pw_main) begin
      st_nxt.pf = 1'b1;
    end
    // read data, registered on the cycle's first clock
    st_nxt.rd = 8'h00;
    case (addr)
      `ADDR_FLAGS: st_nxt.rd = {st_r.watchdog_flag, st_r.af, st_r.pf, 5'h00};
      `ADDR_ALM_SEC: st_nxt.rd = st_r.alm_sec;
      `ADDR_ALM_MIN: st_nxt.rd = st_r.alm_min;
      `ADDR_ALM_HOUR: st_nxt.rd = st_r.alm_hour;
      `ADDR_ALM_DATE: st_nxt.rd = st_r.alm_date;
      `ADDR_IRQ: st_nxt.rd = st_r.irq_cfg;
      `ADDR_WDOG: st_nxt.rd = {1'b0, st_r.wdog[6:0]};
      default: st_nxt.rd = 8'h00;
    endcase
    if (st_r.in_cyc) begin
      st_nxt.rd = st_r.rd;
    end
    // any single enabled source is enough
    st_nxt.irq = (st_r.watchdog_flag && st_r.irq_cfg[`BIT_WIE])
      || (st_r.af && st_r.irq_cfg[`BIT_AIE])
      || (st_r.pf && st_r.irq_cfg[`BIT_PFE]);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.pw <= pw_off;
      st_r.irq_cfg <= `IRQ_RESET;
      st_r.wdog <= `WDOG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rd;
  // output enable is also gated by lockout, so nothing is driven while below lockout
  assign rdata_oe_b = !(st_r.in_cyc && !ce_b && !oe_b && we_b && !lockout);
  assign on_backup_supply = st_r.bk;
  assign irq_active = st_r.irq;
endmodule // rtc_supervisor_alarm_watchdog

// ===== sim/supervisor_monitor.sv
// assertions on the supervisor top ports
`timescale 1ns/1ps
module supervisor_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce_b,
  input wire logic we_b,
  input wire logic rdata_oe_b,
  input wire logic below_interrupt_threshold,
  input wire logic below_lockout_threshold,
  input wire logic below_backup_supply,
  input wire logic on_backup_supply,
  input wire logic irq_active
);
  logic [3:0] idle_r;
  // cycles since chip enable was low, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) idle_r <= 4'hf;
    else idle_r <= !ce_b ? 4'h0 : idle_r + {3'h0, idle_r != 4'hf};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_bk_on; $rose(below_backup_supply) |-> ##[1:3] on_backup_supply; endproperty
  a_bk_on: assert property (p_bk_on) else $error("late backup");
  property p_bk_off; $fell(on_backup_supply) |-> !$past(below_backup_supply); endproperty
  a_bk_off: assert property (p_bk_off) else $error("early main");
  property p_lock; below_lockout_threshold && $past(below_lockout_threshold) |-> rdata_oe_b; endproperty
  a_lock: assert property (p_lock) else $error("driven in lockout");
  property p_wr; !we_b |-> rdata_oe_b; endproperty
  a_wr: assert property (p_wr) else $error("driven in write");
  property p_idle; ce_b && $past(ce_b) |-> rdata_oe_b; endproperty
  a_idle: assert property (p_idle) else $error("driven when idle");
  property p_pf; below_interrupt_threshold [*2] |-> ##[1:3] irq_active; endproperty
  a_pf: assert property (p_pf) else $error("no power fail irq");
  property p_hold; $fell(irq_active) |-> idle_r < 4'h8; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped alone");
  property p_rst; $rose(rst_b) |-> rdata_oe_b [*2]; endproperty
  a_rst: assert property (p_rst) else $error("driven before main");
  c_irq: cover property ($rose(irq_active));
  c_bk: cover property ($rose(on_backup_supply));
  c_rd: cover property (!rdata_oe_b);
endmodule // supervisor_monitor

// ===== sim/host_model.sv
// host model driving the parallel register bus
`timescale 1ns/1ps
module host_model import supervisor_pkg::*; (
  input wire logic clk,
  input wire byte_t rdata,
  input wire logic rdata_oe_b,
  output logic ce_b = 1'b1, // high from time zero through power-up
  output logic oe_b = 1'b1,
  output logic we_b = 1'b1,
  output logic [14:0] addr = 15'h0000,
  output byte_t wdata = 8'h00
);
  task automatic cyc(input logic w, input logic [14:0] a, input byte_t d, output byte_t q);
    @(negedge clk);
    ce_b = 1'b0;
    we_b = !w; // stays high through a read so flags may clear
    oe_b = w;
    addr = a;
    wdata = d;
    repeat (2) @(negedge clk);
    // an undriven bus reads back as the inverse, so a refused read cannot pass
    q = rdata_oe_b ? ~rdata : rdata;
    ce_b = 1'b1;
    we_b = 1'b1;
    oe_b = 1'b1;
    // released lines show no stale value
    addr = ~a;
    wdata = ~d;
  endtask
endmodule // host_model

// ===== sim/rtc_supervisor_alarm_watchdog_tb_top.sv
// self-checking bench for the supervisor block
`timescale 1ns/1ps
module rtc_supervisor_alarm_watchdog_tb_top import supervisor_pkg::*; ();
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sec_update = 1'b0;
  logic osc_enable_n = 1'b0;
  logic bi = 1'b0;
  logic bl = 1'b0;
  logic bb = 1'b0;
  logic bg = 1'b1;
  logic ce_b, oe_b, we_b, rdata_oe_b, on_backup_supply, irq_active, hit;
  logic [14:0] addr;
  logic [15:0] rnd = 16'h8594;
  byte_t wdata, rdata, q;
  byte_t tod [4] = '{default: 8'h00};
  byte_t alm [4];
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [14:0] ra [5] = '{15'h7ff0, 15'h7ff0, 15'h7ff6, 15'h7ff7, 15'h0123};
  byte_t re [5] = '{8'h20, 8'h00, 8'h24, 8'h00, 8'h00};
  byte_t lw [4] = '{8'h45, 8'h7f, 8'h00, 8'h00};
  byte_t le [4] = '{8'h45, 8'h45, 8'h05, 8'h00};
  rtc_supervisor_alarm_watchdog #(.TICK_CYCLES(4)) u_rtc_supervisor_alarm_watchdog (
    .clk(clk), .rst_b(rst_b), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rdata_oe_b(rdata_oe_b), .sec_update(sec_update),
    .tod_sec(tod[0]), .tod_min(tod[1]), .tod_hour(tod[2]), .tod_date(tod[3]),
    .osc_enable_n(osc_enable_n), .bandgap_ok(bg), .below_interrupt_threshold(bi),
    .below_lockout_threshold(bl), .below_backup_supply(bb),
    .on_backup_supply(on_backup_supply), .irq_active(irq_active));
  host_model u_host_model (.clk(clk), .rdata(rdata), .rdata_oe_b(rdata_oe_b), .ce_b(ce_b), .oe_b(oe_b),
    .we_b(we_b), .addr(addr), .wdata(wdata));
  always #25 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [14:0] a, input byte_t d);
    u_host_model.cyc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [14:0] a);
    u_host_model.cyc(1'b0, a, 8'h00, q);
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a hang counts as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      chk("reg", q, re[i]);
    end
    wr(15'h7ff6, 8'h64);
    for (int m = 0; m < 16; m++) begin
      hit = 1'b1;
      for (int f = 0; f < 4; f++) begin
        rnd = lfsr(rnd);
        alm[f] = {m[f], rnd[6:0]};
        wr(15'h7ff2 + 15'(f), alm[f]);
        tod[f] = {1'b0, (rnd[7] | rnd[8]) ? rnd[6:0] : rnd[14:8]};
        if (!m[f] && tod[f][6:0] != alm[f][6:0]) hit = 1'b0;
      end
      @(negedge clk) sec_update = 1'b1;
      @(negedge clk) sec_update = 1'b0;
      repeat (4) @(negedge clk);
      chk("alarm_irq", irq_active, hit);
      rd(15'h7ff0);
      chk("alarm", q, {1'b0, hit, 6'h00});
    end
    wr(15'h7ff6, 8'ha4);
    // strobes every three cycles, well inside a three-tick timeout
    repeat (9) wr(15'h7ff7, 8'h83);
    rd(15'h7ff0);
    chk("wd_early", q, 8'h00);
    repeat (40) @(negedge clk);
    chk("wd_irq", irq_active, 1'b1);
    rd(15'h7ff0);
    chk("wd_flag", q, 8'h80);
    osc_enable_n = 1'b1;
    wr(15'h7ff7, 8'h83);
    repeat (40) @(negedge clk);
    rd(15'h7ff0);
    chk("wd_osc", q, 8'h00);
    osc_enable_n = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(15'h7ff7, lw[i]);
      rd(15'h7ff7);
      chk("wd_lock", q, le[i]);
    end
    rd(15'h7ff0);
    wr(15'h7ff7, 8'h80);
    repeat (40) @(negedge clk);
    rd(15'h7ff0);
    chk("wd_off", q, 8'h00);
    bi = 1'b1;
    repeat (5) @(negedge clk);
    bi = 1'b0;
    wr(15'h7ff0, 8'h00);
    rd(15'h7ff0);
    chk("pf_held", q, 8'h20);
    rd(15'h7ff0);
    chk("pf_clr", q, 8'h00);
    bb = 1'b1;
    repeat (4) @(negedge clk);
    chk("backup", on_backup_supply, 1'b1);
    bb = 1'b0;
    bl = 1'b1;
    wr(15'h7ff6, 8'h00);
    bl = 1'b0;
    repeat (8) @(negedge clk);
    rd(15'h7ff6);
    chk("lockout", q, 8'ha4);
    // monitor drops out and comes back: reassert backup and power fail first
    bg = 1'b0;
    repeat (3) @(negedge clk);
    bg = 1'b1;
    repeat (2) @(negedge clk);
    chk("reassert_bk", on_backup_supply, 1'b1);
    repeat (2) @(negedge clk);
    chk("main_bk", on_backup_supply, 1'b0);
    rd(15'h7ff0);
    chk("reassert_pf", q, 8'h20);
    end_of_test;
  end
endmodule // rtc_supervisor_alarm_watchdog_tb_top
bind rtc_supervisor_alarm_watchdog supervisor_monitor u_supervisor_monitor (.clk(clk),
  .rst_b(rst_b), .ce_b(ce_b), .we_b(we_b), .rdata_oe_b(rdata_oe_b),
  .below_interrupt_threshold(below_interrupt_threshold),
  .below_lockout_threshold(below_lockout_threshold),
  .below_backup_supply(below_backup_supply),
  .on_backup_supply(on_backup_supply), .irq_active(irq_active));
